// ---- logic/mftw_chain.sv ----
// mftw_chain: divide-by-four prescaler and fifteen-stage counter chain
// assumes the bus clock and a synchronous clear from the parent
`timescale 1ns/1ps
module mftw_chain #(
  parameter int PRE_W = mftw_pkg::PRE_BITS,
  parameter int STG_W = mftw_pkg::STAGES
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  output logic [PRE_W-1:0]      pre,
  output logic [STG_W-1:0]      count,
  output logic                  adv
);
  import mftw_pkg::*;

  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_next;
  logic [STG_W-1:0] cnt_reg;
  logic [STG_W-1:0] cnt_next;

  // ----------------------------------------------------------------
  // prescaler and chain
  // ----------------------------------------------------------------
  assign adv      = &pre_reg;
  assign pre_next = clear ? '0 : pre_reg + PRE_W'(1);
  assign cnt_next = clear ? '0 : (adv ? cnt_reg + STG_W'(1) : cnt_reg);
  assign pre      = pre_reg;
  assign count    = cnt_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= '0;
      cnt_reg <= '0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_chain_rate: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(clear) && (cnt_reg != $past(cnt_reg)) |-> $past(pre_reg) == '1)
    else $error("chain moved without prescaler carry");
  a_chain_clear: assert property (@(posedge clk) disable iff (!rst_n)
    clear |=> cnt_reg == '0 && pre_reg == '0)
    else $error("chain not cleared");

endmodule // mftw_chain

// ---- logic/mftw_pkg.sv ----
// mftw_pkg: constants and types of the timer/watchdog block
// assumes a 12-bit-address register port with byte-wide data
package mftw_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CSR_OFS  = 12'h008;
  localparam logic [11:0] CNT_OFS  = 12'h009;
  localparam logic [11:0] WDOG_OFS = 12'hff0;

  // ----------------------------------------------------------------
  // control/status fields
  // ----------------------------------------------------------------
  localparam int OVF_FLAG_BIT = 7;
  localparam int PER_FLAG_BIT = 6;
  localparam int OVF_EN_BIT   = 5;
  localparam int PER_EN_BIT   = 4;
  localparam int OVF_ACK_BIT  = 3;
  localparam int PER_ACK_BIT  = 2;
  localparam int RATE_HI_BIT  = 1;
  localparam int RATE_LO_BIT  = 0;
  localparam int WDOG_CLR_BIT = 0;
  localparam logic [1:0] RATE_RST = 2'h3;

  // ----------------------------------------------------------------
  // chain geometry and timing
  // ----------------------------------------------------------------
  localparam int PRE_BITS   = 2;
  localparam int STAGES     = 15;
  localparam int CNT_BITS   = 8;
  localparam int TAP_BASE   = 11;
  localparam int COP_BITS   = 3;
  localparam logic [16:0] POR_SHORT_CYC = 17'h000e0;
  localparam logic [16:0] POR_LONG_CYC  = 17'h00fe0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } mftw_bus_req_t;

  typedef enum logic [1:0] {
    ST_POR = 2'b01,
    ST_RUN = 2'b10
  } mftw_state_t;

endpackage

// ---- logic/mftw_timer.sv ----
// mftw_timer: multi-function timer with periodic interrupt and watchdog
// assumes synchronous inputs and a one-cycle strobe register port
// Function
// - timer is a fifteen-stage counter chain serving all functions
// - chain advances once per four bus clocks, also in wait and halt
// - low eight stages readable anytime without disturbing the count
// - overflow taken from eighth stage, every 1024 clocks
// - upper stages give periodic rates 2^14..2^17, chosen by rate bits
// - power-on delay is 224 or 4064 cycles by build option
// - power-on clears chain, waits delay, releases, clears chain again
// - external reset clears the whole chain
// - optional watchdog divides periodic output by eight
// - watchdog timeout raises an internal reset
// - writing zero to bit 0 of clear location resets only the divider
// - counter register read-only, writes ignored, zero after reset
// - control bits 2 and 3 are write-only and read as zero
// - overflow flag read-only, set when counter wraps to zero
// - overflow flag with its enable requests the timer interrupt
// - overflow flag cleared by ack write or reset, not direct write
// - periodic flag set by selected tap, gated by enable, ack clears
// - ack bits read zero and are unaffected by reset
// - reset sets both rate bits; codes pick 16384..131072
// - entry to stop mode clears the whole chain
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module mftw_timer #(
  parameter bit COP_EN   = 1'b1,
  parameter bit POR_LONG = 1'b0,
  parameter int TAP_LO   = mftw_pkg::TAP_BASE
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ext_reset_n,
  input  wire logic                  stop_entry,
  input  wire mftw_pkg::mftw_bus_req_t bus_req,
  output logic [7:0]                 rd_data,
  output logic                       timer_irq,
  output logic                       por_busy,
  output logic                       cop_reset
);
  import mftw_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [16:0] POR_CYC = POR_LONG ? POR_LONG_CYC : POR_SHORT_CYC;

  mftw_state_t      state_reg;
  mftw_state_t      state_next;
  logic [1:0]       pre;
  logic [STAGES-1:0] cnt;
  logic             adv;
  logic             chain_clear;
  logic             sys_rst;
  logic             por_done;
  logic [16:0]      elapsed;
  logic [3:0]       tap_carry;
  logic             ovf_evt;
  logic             rti_evt;
  logic             cop_evt;
  logic             wr_csr;
  logic             wr_wdog;
  logic             rd_csr;
  logic             rd_cnt;
  logic             ovf_ack;
  logic             per_ack;
  logic             wdog_clr;
  logic [1:0]       rate_reg;
  logic [1:0]       rate_next;
  logic             ovf_en_reg;
  logic             ovf_en_next;
  logic             per_en_reg;
  logic             per_en_next;
  logic             ovf_flag_reg;
  logic             ovf_flag_next;
  logic             per_flag_reg;
  logic             per_flag_next;
  logic [COP_BITS-1:0] cop_div_reg;
  logic [COP_BITS-1:0] cop_div_next;
  logic             cop_reset_reg;
  logic             por_busy_reg;
  logic             irq_reg;
  logic             irq_next;
  logic [7:0]       csr_view;
  logic [7:0]       rd_next;
  logic [7:0]       rd_data_reg;

  // ----------------------------------------------------------------
  // counter chain
  // ----------------------------------------------------------------
  mftw_chain #(
    .PRE_W (PRE_BITS),
    .STG_W (STAGES)
  ) u_chain (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (chain_clear),
    .pre   (pre),
    .count (cnt),
    .adv   (adv)
  );

  // ----------------------------------------------------------------
  // power-on delay and internal reset
  // ----------------------------------------------------------------
  assign elapsed    = {cnt, pre};
  assign por_done   = (state_reg == ST_POR) && (elapsed == POR_CYC - 17'h1);
  assign sys_rst    = !ext_reset_n || por_busy_reg || cop_reset_reg;
  assign chain_clear = por_done || !ext_reset_n || stop_entry
                    || cop_reset_reg;

  always_comb begin
    case (state_reg)
      ST_POR:  state_next = por_done ? ST_RUN : ST_POR;
      ST_RUN:  state_next = ST_RUN;
      default: state_next = ST_POR;
    endcase
  end

  // ----------------------------------------------------------------
  // chain events
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tap
      assign tap_carry[g] = &cnt[TAP_LO+g:0];
    end
  endgenerate

  assign ovf_evt = adv && (&cnt[CNT_BITS-1:0]) && !chain_clear;
  assign rti_evt = adv && tap_carry[rate_reg] && !chain_clear;
  assign cop_evt = COP_EN && rti_evt && (&cop_div_reg);

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  assign wr_csr   = bus_req.wr && (bus_req.addr == CSR_OFS) && !sys_rst;
  assign wr_wdog  = bus_req.wr && (bus_req.addr == WDOG_OFS);
  assign rd_csr   = bus_req.rd && (bus_req.addr == CSR_OFS);
  assign rd_cnt   = bus_req.rd && (bus_req.addr == CNT_OFS);
  assign ovf_ack  = wr_csr && bus_req.wdata[OVF_ACK_BIT];
  assign per_ack  = wr_csr && bus_req.wdata[PER_ACK_BIT];
  assign wdog_clr = wr_wdog && !bus_req.wdata[WDOG_CLR_BIT];

  // ----------------------------------------------------------------
  // control, flags and watchdog next values
  // ----------------------------------------------------------------
  assign rate_next   = sys_rst ? RATE_RST
                     : (wr_csr ? bus_req.wdata[RATE_HI_BIT:RATE_LO_BIT] : rate_reg);
  assign ovf_en_next = sys_rst ? 1'b0 : (wr_csr ? bus_req.wdata[OVF_EN_BIT] : ovf_en_reg);
  assign per_en_next = sys_rst ? 1'b0 : (wr_csr ? bus_req.wdata[PER_EN_BIT] : per_en_reg);
  assign ovf_flag_next = sys_rst ? 1'b0
                       : (ovf_evt || (ovf_flag_reg && !ovf_ack));
  assign per_flag_next = sys_rst ? 1'b0
                       : (rti_evt || (per_flag_reg && !per_ack));
  assign cop_div_next  = (sys_rst || !COP_EN) ? '0
                       : (rti_evt ? cop_div_reg + COP_BITS'(1)
                       : (wdog_clr ? '0 : cop_div_reg));
  assign irq_next = (ovf_flag_reg && ovf_en_reg)
                 || (per_flag_reg && per_en_reg);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  assign csr_view = {ovf_flag_reg, per_flag_reg, ovf_en_reg, per_en_reg,
                     2'h0, rate_reg};
  assign rd_next  = rd_csr ? csr_view
                  : (rd_cnt ? cnt[CNT_BITS-1:0] : 8'h00);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_POR;
      por_busy_reg <= 1'b1;
    end else begin
      state_reg    <= state_next;
      por_busy_reg <= (state_next == ST_POR);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_reg     <= RATE_RST;
      ovf_en_reg   <= 1'b0;
      per_en_reg   <= 1'b0;
      ovf_flag_reg <= 1'b0;
      per_flag_reg <= 1'b0;
    end else begin
      rate_reg     <= rate_next;
      ovf_en_reg   <= ovf_en_next;
      per_en_reg   <= per_en_next;
      ovf_flag_reg <= ovf_flag_next;
      per_flag_reg <= per_flag_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cop_div_reg   <= '0;
      cop_reset_reg <= 1'b0;
      irq_reg       <= 1'b0;
      rd_data_reg   <= 8'h00;
    end else begin
      cop_div_reg   <= cop_div_next;
      cop_reset_reg <= cop_evt;
      irq_reg       <= irq_next;
      rd_data_reg   <= rd_next;
    end
  end

  assign rd_data   = rd_data_reg;
  assign timer_irq = irq_reg;
  assign por_busy  = por_busy_reg;
  assign cop_reset = cop_reset_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ovf_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    ovf_evt && !sys_rst |=> ovf_flag_reg && cnt[CNT_BITS-1:0] == 8'h00)
    else $error("overflow flag not set on wrap");
  a_ovf_ack_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ovf_ack && !ovf_evt |=> !ovf_flag_reg)
    else $error("overflow ack did not clear flag");
  a_flag_no_direct: assert property (@(posedge clk) disable iff (!rst_n)
    wr_csr && !bus_req.wdata[OVF_ACK_BIT] && ovf_flag_reg |=> ovf_flag_reg)
    else $error("direct write changed overflow flag");
  a_irq_from_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (ovf_flag_reg && ovf_en_reg) || (per_flag_reg && per_en_reg) |=> timer_irq)
    else $error("timer interrupt missing");
  a_per_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    rti_evt && !sys_rst |=> per_flag_reg ##1 (per_flag_reg || $past(per_ack) || $past(sys_rst)))
    else $error("periodic flag not set");
  a_per_ack_clear: assert property (@(posedge clk) disable iff (!rst_n)
    per_ack && !rti_evt |=> !per_flag_reg)
    else $error("periodic ack did not clear flag");
  a_per_no_direct: assert property (@(posedge clk) disable iff (!rst_n)
    wr_csr && !bus_req.wdata[PER_ACK_BIT] && per_flag_reg |=> per_flag_reg)
    else $error("direct write changed periodic flag");
  a_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !((ovf_flag_reg && ovf_en_reg) || (per_flag_reg && per_en_reg)) |=> !timer_irq)
    else $error("timer interrupt without gated flag");
  a_rate_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_csr |=> rate_reg == $past(bus_req.wdata[RATE_HI_BIT:RATE_LO_BIT]))
    else $error("rate bits not taken from write");
  a_csr_wo_bits: assert property (@(posedge clk) disable iff (!rst_n)
    rd_csr |=> rd_data[OVF_ACK_BIT] == 1'b0 && rd_data[PER_ACK_BIT] == 1'b0)
    else $error("write-only bits read nonzero");

  // ----------------------------------------------------------------
  // checks: chain, reset and watchdog
  // ----------------------------------------------------------------
  a_cnt_read: assert property (@(posedge clk) disable iff (!rst_n)
    rd_cnt |=> rd_data == $past(cnt[CNT_BITS-1:0]))
    else $error("counter read mismatch");
  a_cnt_read_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    rd_cnt && !chain_clear && !adv |=> $stable(cnt))
    else $error("counter read disturbed count");
  a_cnt_no_write: assert property (@(posedge clk) disable iff (!rst_n)
    bus_req.wr && bus_req.addr == CNT_OFS && !chain_clear && !adv |=> $stable(cnt))
    else $error("counter write changed count");
  a_ext_clear: assert property (@(posedge clk) disable iff (!rst_n)
    !ext_reset_n |=> cnt == '0 && pre == '0)
    else $error("external reset did not clear chain");
  a_flags_ext_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !ext_reset_n |=> !ovf_flag_reg && !per_flag_reg)
    else $error("flags not cleared by reset");
  a_rate_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !ext_reset_n |=> rate_reg == RATE_RST && !ovf_en_reg && !per_en_reg)
    else $error("reset values wrong");
  a_cop_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    cop_evt |=> cop_reset ##1 (cnt == '0 && !cop_reset))
    else $error("watchdog timeout not handled");
  a_cop_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wdog_clr && !rti_evt && !sys_rst |=> cop_div_reg == '0 && $stable(rate_reg))
    else $error("watchdog clear failed");
  a_wdog_ignore_one: assert property (@(posedge clk) disable iff (!rst_n)
    wr_wdog && bus_req.wdata[WDOG_CLR_BIT] && !rti_evt && !sys_rst |=> $stable(cop_div_reg))
    else $error("watchdog cleared by a one");
  a_cop_after_eight: assert property (@(posedge clk) disable iff (!rst_n)
    cop_reset |-> $past(cop_div_reg) == {COP_BITS{1'b1}} && $past(rti_evt))
    else $error("watchdog fired early");
  a_cop_reset_csr: assert property (@(posedge clk) disable iff (!rst_n)
    cop_reset |=> rate_reg == RATE_RST && !ovf_flag_reg && !per_flag_reg)
    else $error("watchdog reset left control state");
  a_por_release: assert property (@(posedge clk) disable iff (!rst_n)
    por_done |=> !por_busy && cnt == '0 && pre == '0)
    else $error("power-on release wrong");
  a_stop_clear: assert property (@(posedge clk) disable iff (!rst_n)
    stop_entry |=> cnt == '0)
    else $error("stop entry did not clear chain");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  c_ovf_flag: cover property (@(posedge clk) disable iff (!rst_n) ovf_evt);
  c_per_flag: cover property (@(posedge clk) disable iff (!rst_n) rti_evt);
  c_cop_reset: cover property (@(posedge clk) disable iff (!rst_n) cop_evt);
  c_por_done: cover property (@(posedge clk) disable iff (!rst_n) por_done);
  c_wdog_clear: cover property (@(posedge clk) disable iff (!rst_n) wdog_clr);

endmodule // mftw_timer

// ---- verification/mftw_timer_tb_top.sv ----
// mftw_timer_tb_top: self-checking bench for the timer/watchdog block
// assumes mftw_pkg compiled first and a shortened periodic tap
`timescale 1ns/1ps
module mftw_timer_tb_top;
  import mftw_pkg::*;

  localparam int TAP_LO_TB = 8;
  localparam int PER_CYC   = 1 << (TAP_LO_TB + 3);

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct {
    logic [11:0] waddr;
    logic [7:0]  wdata;
    logic [11:0] raddr;
    logic [7:0]  exp;
  } mftw_row_t;

  logic          clk;
  logic          rst_n;
  logic          ext_reset_n;
  logic          stop_entry;
  mftw_bus_req_t bus_req;
  logic [7:0]    rd_data;
  logic          timer_irq;
  logic          por_busy;
  logic          cop_reset;
  int            errors;
  int            comparisons;
  int            n;
  time           t0;
  logic [7:0]    v1;
  logic [7:0]    v2;
  mftw_row_t     rows [5];

  mftw_timer #(
    .TAP_LO (TAP_LO_TB)
  ) dut (
    .clk         (clk),
    .rst_n       (rst_n),
    .ext_reset_n (ext_reset_n),
    .stop_entry  (stop_entry),
    .bus_req     (bus_req),
    .rd_data     (rd_data),
    .timer_irq   (timer_irq),
    .por_busy    (por_busy),
    .cop_reset   (cop_reset)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bus_rd(a, d);
    chk(d, exp);
  endtask

  task automatic ext_pulse();
    @(posedge clk);
    ext_reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    ext_reset_n <= 1'b1;
    t0 = $time;
  endtask

  task automatic wait_high(input int which, input int limit);
    int k;
    k = 0;
    while (((which == 0) ? timer_irq : cop_reset) !== 1'b1 && k < limit) begin
      @(negedge clk);
      k++;
    end
    n = int'(($time - t0) / 50);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #(40000 * 50);
    errors++;
    $display("unexpected at %0t: run did not finish", $time);
    end_of_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ext_reset_n = 1'b1;
    stop_entry = 1'b0;
    bus_req = '0;
    errors = 0;
    comparisons = 0;
    rows = '{'{CSR_OFS, 8'h3c, CSR_OFS, 8'h30}, '{CSR_OFS, 8'hc1, CSR_OFS, 8'h01},
             '{CSR_OFS, 8'h02, CSR_OFS, 8'h02}, '{12'h100, 8'h55, 12'h100, 8'h00},
             '{CSR_OFS, 8'h00, CSR_OFS, 8'h00}};
    repeat (4) @(posedge clk);
    chk({5'h00, por_busy, timer_irq, cop_reset}, 8'h04);
    chk(rd_data, 8'h00);
    rst_n <= 1'b1;
    t0 = $time;
    n = 0;
    while (por_busy !== 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n >= 220 && n <= 228), 8'h01);
    rd_chk(CSR_OFS, {6'h00, RATE_RST});
    bus_rd(CNT_OFS, v1);
    chk(8'(v1 <= 8'h03), 8'h01);
    $display("reset test done");
    foreach (rows[i]) begin
      bus_wr(rows[i].waddr, rows[i].wdata);
      rd_chk(rows[i].raddr, rows[i].exp);
    end
    bus_rd(CNT_OFS, v1);
    bus_wr(CNT_OFS, 8'haa);
    bus_rd(CNT_OFS, v2);
    chk(v2, v1 + 8'h01);
    @(posedge clk);
    stop_entry <= 1'b1;
    @(posedge clk);
    stop_entry <= 1'b0;
    bus_rd(CNT_OFS, v1);
    chk(8'(v1 <= 8'h01), 8'h01);
    $display("register test done");
    ext_pulse();
    bus_wr(CSR_OFS, 8'h20);
    wait_high(0, 2000);
    chk(8'(n >= 1020 && n <= 1034), 8'h01);
    rd_chk(CSR_OFS, 8'ha0);
    bus_wr(CSR_OFS, 8'h20);
    rd_chk(CSR_OFS, 8'ha0);
    bus_wr(CSR_OFS, 8'h28);
    rd_chk(CSR_OFS, 8'h20);
    @(negedge clk);
    chk({7'h00, timer_irq}, 8'h00);
    $display("overflow test done");
    ext_pulse();
    bus_wr(CSR_OFS, 8'h10);
    wait_high(0, 4 * PER_CYC);
    chk(8'(n >= PER_CYC - 4 && n <= PER_CYC + 10), 8'h01);
    bus_wr(CSR_OFS, 8'h14);
    @(negedge clk);
    @(negedge clk);
    chk({7'h00, timer_irq}, 8'h00);
    bus_wr(WDOG_OFS, 8'h00);
    wait_high(0, 4 * PER_CYC);
    chk(8'(n >= 2 * PER_CYC - 4 && n <= 2 * PER_CYC + 10), 8'h01);
    bus_wr(WDOG_OFS, 8'h01);
    wait_high(1, 12 * PER_CYC);
    chk(8'(n >= 9 * PER_CYC - 4 && n <= 9 * PER_CYC + 10), 8'h01);
    t0 = $time;
    repeat (3) @(negedge clk);
    rd_chk(CSR_OFS, 8'h03);
    bus_rd(CNT_OFS, v1);
    chk(8'(v1 <= 8'h02), 8'h01);
    bus_wr(CSR_OFS, 8'h11);
    wait_high(0, 4 * PER_CYC);
    chk(8'(n >= 2 * PER_CYC && n <= 2 * PER_CYC + 10), 8'h01);
    $display("watchdog test done");
    end_of_test();
  end

endmodule // mftw_timer_tb_top
